// [sisc_pkg.sv]
// Package with register map, field positions, reset values and timing for the sensor alert block
package sisc_pkg;

   // Register indices on the serial bus
   localparam logic [7:0] STATUS_ADDR     = 8'h00;
   localparam logic [7:0] CONFIG_ADDR     = 8'h01;

   // Reset values
   localparam logic [7:0] STATUS_RST      = 8'h04;
   localparam logic [7:0] CONFIG_RST      = 8'h20;

   // Status field positions
   localparam int AMB_FLAG_BIT    = 0;
   localparam int PRX_FLAG_BIT    = 1;
   localparam int PWR_FLAG_BIT    = 2;
   localparam int SAVE_BIT        = 3;
   localparam int SRST_BIT        = 4;

   // Main configuration field positions
   localparam int AMB_EN_BIT      = 0;
   localparam int PRX_EN_BIT      = 1;
   localparam int SEL_LSB         = 2;
   localparam int MODE_LSB        = 5;

   // Ambient source select codes
   localparam logic [1:0] SEL_CLEAR       = 2'h0;
   localparam logic [1:0] SEL_GREEN       = 2'h1;
   localparam logic [1:0] SEL_IR          = 2'h2;
   localparam logic [1:0] SEL_TEMP        = 2'h3;

   // Channel set codes
   localparam logic [2:0] MODE_CLR_IR_PRX = 3'h3;
   localparam logic [2:0] MODE_ALL_PRX    = 3'h4;
   localparam logic [2:0] MODE_PRX_ONLY   = 3'h5;

   // Timing
   localparam int CLK_HZ          = 10_000_000;
   localparam int CONV_PERIOD_US  = 100_000;
   localparam int CONV_CYCLES     = (CLK_HZ / 1_000_000) * CONV_PERIOD_US;
   localparam int SRST_NS         = 1_600;
   localparam int SRST_CYCLES     = (SRST_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;

   // Serial interface
   localparam logic [6:0] DEV_ADDR_DEF    = 7'h2A; // Value arbitrary

endpackage

// [sisc_conv_if.sv]
// Interface between the register core and the conversion period timer
`timescale 1ns/1ps
interface sisc_conv_if;
   logic       power_save;   // Conversions stopped
   logic [7:0] cfg;          // Configuration as last written
   logic       conv_done;    // One-cycle pulse at end of a conversion period
   logic [7:0] active_cfg;   // Configuration applied to the running period
   logic       stale;        // Data not yet refreshed since wake-up

   modport timer (
      input  power_save,
      input  cfg,
      output conv_done,
      output active_cfg,
      output stale
   );

   modport core (
      output power_save,
      output cfg,
      input  conv_done,
      input  active_cfg,
      input  stale
   );
endinterface

// [sisc_conv_timer.sv]
// Conversion period timer: paces conversions and applies new settings at period boundaries
`timescale 1ns/1ps
module sisc_conv_timer #(
   parameter int PERIOD_CYCLES = sisc_pkg::CONV_CYCLES
) (
   // Clock and reset
   input  wire logic     mclk_i,
   input  wire logic     rst_n_i,
   // Core side
   sisc_conv_if.timer    conv
);

   logic [31:0] cnt_reg;

   // Period counter, held at zero in power save so no conversion runs
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || conv.power_save) begin
         cnt_reg <= 32'h0;
      end else if (cnt_reg == 32'(PERIOD_CYCLES - 1)) begin
         cnt_reg <= 32'h0;
      end else begin
         cnt_reg <= cnt_reg + 32'h1;
      end
   end

   assign conv.conv_done = !conv.power_save && (cnt_reg == 32'(PERIOD_CYCLES - 1));

   // Settings are taken only between periods so a running conversion is never disturbed
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         conv.active_cfg <= sisc_pkg::CONFIG_RST;
      end else if (conv.power_save || conv.conv_done) begin
         conv.active_cfg <= conv.cfg;
      end
   end

   // Data counts as stale from shutdown until the first completed period
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         conv.stale <= 1'b1;
      end else if (conv.power_save) begin
         conv.stale <= 1'b1;
      end else if (conv.conv_done) begin
         conv.stale <= 1'b0;
      end
   end

endmodule

// [sisc_persist.sv]
// Window compare with persist counter producing a qualified threshold event
`timescale 1ns/1ps
module sisc_persist #(
   parameter int W = 14
) (
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         rst_n_i,
   // Control
   input  wire logic         clear_i,
   input  wire logic         sample_i,
   input  wire logic [1:0]   persist_i,
   // Data and window
   input  wire logic [W-1:0] value_i,
   input  wire logic [W-1:0] upper_i,
   input  wire logic [W-1:0] lower_i,
   // Result
   output      logic         event_o
);

   logic [2:0] run_reg;
   logic       outside;

   assign outside = (value_i > upper_i) || (value_i < lower_i);

   // Counts consecutive out-of-window samples; fires once the run exceeds the persist count
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || clear_i) begin
         run_reg <= 3'h0;
         event_o <= 1'b0;
      end else if (sample_i) begin
         if (!outside) begin
            run_reg <= 3'h0;
            event_o <= 1'b0;
         end else if (run_reg >= {1'b0, persist_i}) begin
            event_o <= 1'b1; // Saturates; the sticky flag in the core holds it
         end else begin
            run_reg <= run_reg + 3'h1;
            event_o <= 1'b0;
         end
      end else begin
         event_o <= 1'b0;
      end
   end

endmodule

// [sisc_core.sv]
// Sensor alert core: serial register access, event flags, power save and soft reset
`timescale 1ns/1ps
module sisc_core #(
   parameter logic [6:0] DEV_ADDR    = sisc_pkg::DEV_ADDR_DEF,
   parameter int         CONV_CYCLES = sisc_pkg::CONV_CYCLES
) (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // Serial register bus
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output      logic        sda_o,
   output      logic        sda_oe_o,
   // Alert pin, open drain
   output      logic        alert_n_o,
   output      logic        alert_oe_o,
   // Conversion results
   input  wire logic [13:0] clear_data_i,
   input  wire logic [13:0] green_data_i,
   input  wire logic [13:0] ir_data_i,
   input  wire logic [13:0] temp_data_i,
   input  wire logic [9:0]  prox_data_i,
   // Thresholds and persist settings
   input  wire logic [13:0] amb_upper_thr_i,
   input  wire logic [13:0] amb_lower_thr_i,
   input  wire logic [9:0]  prx_upper_thr_i,
   input  wire logic [9:0]  prx_lower_thr_i,
   input  wire logic [1:0]  ambient_persist_count_i,
   input  wire logic [1:0]  proximity_persist_count_i,
   // Supply monitor
   input  wire logic        supply_glitch_i,
   // Status towards the rest of the device
   output      logic        conv_enable_o,
   output      logic        amb_active_o,
   output      logic        prx_active_o,
   output      logic        data_stale_o,
   output      logic        soft_reset_o,
   output      logic        thr_restore_o
);

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_ADDR  = 4'b0001,
      ST_ACK_A = 4'b0010,
      ST_PTR   = 4'b0011,
      ST_ACK_P = 4'b0100,
      ST_WDAT  = 4'b0101,
      ST_ACK_W = 4'b0110,
      ST_RDAT  = 4'b0111,
      ST_RACK  = 4'b1000
   } sisc_bus_state_t;

   sisc_bus_state_t bus_state_reg;
   logic [3:0]  bit_cnt_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  tx_reg;
   logic [7:0]  ptr_reg;
   logic        rw_reg;
   logic        ack_ok_reg;
   logic        scl_q_reg;
   logic        sda_q_reg;
   logic        wr_stb_reg;
   logic [7:0]  wr_addr_reg;
   logic [7:0]  wr_data_reg;
   logic        status_rd_reg;

   logic        ambient_alert_flag_reg;
   logic        proximity_alert_flag_reg;
   logic        power_up_event_flag_reg;
   logic        power_save_request_reg;
   logic [7:0]  cfg_reg;
   logic [7:0]  srst_cnt_reg;
   logic        srst_busy;
   logic        core_rst_n;

   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;
   logic        amb_evt;
   logic        prx_evt;
   logic [13:0] amb_value;
   logic [2:0]  act_mode;

   sisc_conv_if conv ();

   // Register read mux; unmapped indices read as zero
   function automatic logic [7:0] read_reg(input logic [7:0] idx,
                                           input logic [7:0] status,
                                           input logic [7:0] cfg);
      if (idx == sisc_pkg::STATUS_ADDR) begin
         return status;
      end else if (idx == sisc_pkg::CONFIG_ADDR) begin
         return cfg;
      end else begin
         return 8'h00;
      end
   endfunction

   logic [7:0] status_view;
   assign status_view = {3'h0, srst_busy, power_save_request_reg, power_up_event_flag_reg,
                         proximity_alert_flag_reg, ambient_alert_flag_reg};

   // Byte offered to a read, picked by the register pointer
   logic [7:0] rd_byte;
   assign rd_byte = read_reg(ptr_reg, status_view, cfg_reg);

   // Bus pins are synchronous to mclk; one stage of history gives the edges
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= scl_i;
         sda_q_reg <= sda_i;
      end
   end

   assign scl_rise  = scl_i && !scl_q_reg;
   assign scl_fall  = !scl_i && scl_q_reg;
   assign bus_start = scl_i && scl_q_reg && sda_q_reg && !sda_i;
   assign bus_stop  = scl_i && scl_q_reg && !sda_q_reg && sda_i;

   // Serial slave; reset only by the pin reset so a soft reset cannot cut a transfer short
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         bus_state_reg <= ST_IDLE;
         bit_cnt_reg   <= 4'h0;
         shift_reg     <= 8'h00;
         tx_reg        <= 8'h00;
         ptr_reg       <= 8'h00;
         rw_reg        <= 1'b0;
         ack_ok_reg    <= 1'b0;
         sda_oe_o      <= 1'b0;
         wr_stb_reg    <= 1'b0;
         wr_addr_reg   <= 8'h00;
         wr_data_reg   <= 8'h00;
         status_rd_reg <= 1'b0;
      end else begin
         wr_stb_reg    <= 1'b0;
         status_rd_reg <= 1'b0;
         if (bus_stop) begin
            bus_state_reg <= ST_IDLE;
            sda_oe_o      <= 1'b0;
         end else if (bus_start) begin
            bus_state_reg <= ST_ADDR;
            bit_cnt_reg   <= 4'h0;
            sda_oe_o      <= 1'b0;
         end else if (scl_rise) begin
            if (bus_state_reg == ST_RACK) begin
               ack_ok_reg <= !sda_i;
            end else if (bus_state_reg == ST_ADDR || bus_state_reg == ST_PTR ||
                         bus_state_reg == ST_WDAT) begin
               shift_reg   <= {shift_reg[6:0], sda_i};
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
         end else if (scl_fall) begin
            case (bus_state_reg)
               ST_ADDR: begin
                  if (bit_cnt_reg == 4'h8) begin
                     if (shift_reg[7:1] == DEV_ADDR) begin
                        rw_reg        <= shift_reg[0];
                        sda_oe_o      <= 1'b1;
                        bus_state_reg <= ST_ACK_A;
                     end else begin
                        bus_state_reg <= ST_IDLE;
                     end
                  end
               end
               ST_ACK_A, ST_RACK: begin
                  bit_cnt_reg <= 4'h0;
                  if (bus_state_reg == ST_RACK && !ack_ok_reg) begin
                     sda_oe_o      <= 1'b0;
                     bus_state_reg <= ST_IDLE;
                  end else if (bus_state_reg == ST_RACK || rw_reg) begin
                     // Load the byte and drive its first bit
                     tx_reg        <= rd_byte;
                     sda_oe_o      <= !rd_byte[7];
                     bit_cnt_reg   <= 4'h1;
                     status_rd_reg <= (ptr_reg == sisc_pkg::STATUS_ADDR);
                     ptr_reg       <= ptr_reg + 8'h01;
                     bus_state_reg <= ST_RDAT;
                  end else begin
                     sda_oe_o      <= 1'b0;
                     bus_state_reg <= ST_PTR;
                  end
               end
               ST_PTR: begin
                  if (bit_cnt_reg == 4'h8) begin
                     ptr_reg       <= shift_reg;
                     sda_oe_o      <= 1'b1;
                     bus_state_reg <= ST_ACK_P;
                  end
               end
               ST_ACK_P, ST_ACK_W: begin
                  sda_oe_o      <= 1'b0;
                  bit_cnt_reg   <= 4'h0;
                  bus_state_reg <= ST_WDAT;
               end
               ST_WDAT: begin
                  if (bit_cnt_reg == 4'h8) begin
                     wr_stb_reg    <= 1'b1;
                     wr_addr_reg   <= ptr_reg;
                     wr_data_reg   <= shift_reg;
                     ptr_reg       <= ptr_reg + 8'h01;
                     sda_oe_o      <= 1'b1;
                     bus_state_reg <= ST_ACK_W;
                  end
               end
               ST_RDAT: begin
                  if (bit_cnt_reg == 4'h8) begin
                     sda_oe_o      <= 1'b0; // Release for the host's acknowledge
                     bus_state_reg <= ST_RACK;
                  end else begin
                     sda_oe_o    <= !tx_reg[6];
                     tx_reg      <= {tx_reg[6:0], 1'b0};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
               default: begin
                  sda_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end

   assign sda_o = 1'b0;

   // Soft reset sequencer, itself cleared only by the pin reset
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         srst_cnt_reg <= 8'h00;
      end else if (wr_stb_reg && wr_addr_reg == sisc_pkg::STATUS_ADDR &&
                   wr_data_reg[sisc_pkg::SRST_BIT]) begin
         srst_cnt_reg <= 8'(sisc_pkg::SRST_CYCLES);
      end else if (srst_cnt_reg != 8'h00) begin
         srst_cnt_reg <= srst_cnt_reg - 8'h01;
      end
   end

   assign srst_busy    = (srst_cnt_reg != 8'h00);
   assign core_rst_n   = rst_n_i && !srst_busy;
   assign soft_reset_o = srst_busy;

   // Control registers
   always_ff @(posedge mclk_i) begin
      if (!core_rst_n) begin
         power_save_request_reg <= sisc_pkg::STATUS_RST[sisc_pkg::SAVE_BIT];
         cfg_reg                <= sisc_pkg::CONFIG_RST;
      end else if (wr_stb_reg) begin
         if (wr_addr_reg == sisc_pkg::STATUS_ADDR) begin
            power_save_request_reg <= wr_data_reg[sisc_pkg::SAVE_BIT];
         end else if (wr_addr_reg == sisc_pkg::CONFIG_ADDR) begin
            cfg_reg <= wr_data_reg;
         end
      end
   end

   // Power-up flag: set by reset or supply glitch, only a status read clears it
   always_ff @(posedge mclk_i) begin
      if (!core_rst_n) begin
         power_up_event_flag_reg <= sisc_pkg::STATUS_RST[sisc_pkg::PWR_FLAG_BIT];
      end else if (supply_glitch_i) begin
         power_up_event_flag_reg <= 1'b1;
      end else if (status_rd_reg) begin
         power_up_event_flag_reg <= 1'b0;
      end
   end

   // Thresholds outside this block return to defaults on a supply event or soft reset
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         thr_restore_o <= 1'b1;
      end else begin
         thr_restore_o <= supply_glitch_i || srst_busy;
      end
   end

   // Ambient flag; a new event beats a same-cycle read clear
   always_ff @(posedge mclk_i) begin
      if (!core_rst_n) begin
         ambient_alert_flag_reg <= 1'b0;
      end else if (amb_evt && cfg_reg[sisc_pkg::AMB_EN_BIT] && !power_save_request_reg) begin
         ambient_alert_flag_reg <= 1'b1;
      end else if (status_rd_reg || !cfg_reg[sisc_pkg::AMB_EN_BIT] ||
                   power_save_request_reg) begin
         ambient_alert_flag_reg <= 1'b0;
      end
   end

   // Proximity flag, same policy as ambient
   always_ff @(posedge mclk_i) begin
      if (!core_rst_n) begin
         proximity_alert_flag_reg <= 1'b0;
      end else if (prx_evt && cfg_reg[sisc_pkg::PRX_EN_BIT] && !power_save_request_reg) begin
         proximity_alert_flag_reg <= 1'b1;
      end else if (status_rd_reg || !cfg_reg[sisc_pkg::PRX_EN_BIT] ||
                   power_save_request_reg) begin
         proximity_alert_flag_reg <= 1'b0;
      end
   end

   // Open-drain alert: only ever pulls low, the board pull-up gives the high level
   assign alert_n_o  = 1'b0;
   assign alert_oe_o = power_up_event_flag_reg || proximity_alert_flag_reg ||
                       ambient_alert_flag_reg;

   // Conversion pacing
   assign conv.power_save = power_save_request_reg;
   assign conv.cfg        = cfg_reg;

   sisc_conv_timer #(
      .PERIOD_CYCLES (CONV_CYCLES)
   ) u_timer (
      .mclk_i  (mclk_i),
      .rst_n_i (core_rst_n),
      .conv    (conv)
   );

   // Channel set from the applied mode; reserved codes run nothing
   assign act_mode      = conv.active_cfg[sisc_pkg::MODE_LSB +: 3];
   assign amb_active_o  = (act_mode < sisc_pkg::MODE_PRX_ONLY);
   assign prx_active_o  = (act_mode == sisc_pkg::MODE_CLR_IR_PRX) ||
                          (act_mode == sisc_pkg::MODE_ALL_PRX) ||
                          (act_mode == sisc_pkg::MODE_PRX_ONLY);
   assign conv_enable_o = !power_save_request_reg && (amb_active_o || prx_active_o);
   assign data_stale_o  = conv.stale;

   // Ambient source routing into the window compare
   always_comb begin
      case (conv.active_cfg[sisc_pkg::SEL_LSB +: 2])
         sisc_pkg::SEL_CLEAR: amb_value = clear_data_i;
         sisc_pkg::SEL_GREEN: amb_value = green_data_i;
         sisc_pkg::SEL_IR:    amb_value = ir_data_i;
         default:             amb_value = temp_data_i;
      endcase
   end

   sisc_persist #(
      .W (14)
   ) u_amb_persist (
      .mclk_i    (mclk_i),
      .rst_n_i   (core_rst_n),
      .clear_i   (!conv.active_cfg[sisc_pkg::AMB_EN_BIT] || power_save_request_reg),
      .sample_i  (conv.conv_done && amb_active_o),
      .persist_i (ambient_persist_count_i),
      .value_i   (amb_value),
      .upper_i   (amb_upper_thr_i),
      .lower_i   (amb_lower_thr_i),
      .event_o   (amb_evt)
   );

   sisc_persist #(
      .W (10)
   ) u_prx_persist (
      .mclk_i    (mclk_i),
      .rst_n_i   (core_rst_n),
      .clear_i   (!conv.active_cfg[sisc_pkg::PRX_EN_BIT] || power_save_request_reg),
      .sample_i  (conv.conv_done && prx_active_o),
      .persist_i (proximity_persist_count_i),
      .value_i   (prox_data_i),
      .upper_i   (prx_upper_thr_i),
      .lower_i   (prx_lower_thr_i),
      .event_o   (prx_evt)
   );

endmodule

// [sisc_core_asserts.sv]
// Port checker for the sensor alert core
`timescale 1ns/1ps
module sisc_core_asserts (
   // Clock, reset and inputs
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic supply_glitch_i,
   // Outputs watched
   input wire logic sda_o,
   input wire logic alert_n_o,
   input wire logic alert_oe_o,
   input wire logic conv_enable_o,
   input wire logic data_stale_o,
   input wire logic soft_reset_o,
   input wire logic thr_restore_o
);
   // One domain, so clock and disable are shared
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Pins only ever pull low
   alert_pin_a: assert property (alert_n_o == 1'b0 && sda_o == 1'b0)
      else $error("open drain value not low");
   reset_state_a: assert property ($rose(rst_n_i) |-> alert_oe_o && data_stale_o)
      else $error("alert or stale missing after reset");
   glitch_alert_a: assert property (supply_glitch_i |=> alert_oe_o && thr_restore_o)
      else $error("supply event did not alert");
   srst_len_a: assert property ($rose(soft_reset_o) |->
      soft_reset_o[*8] ##1 soft_reset_o[*8] ##1 !soft_reset_o)
      else $error("soft reset length wrong");
   srst_restore_a: assert property (soft_reset_o[*2] |-> thr_restore_o)
      else $error("thresholds not restored in soft reset");
   srst_pwr_a: assert property ($fell(soft_reset_o) |-> ##[0:2] alert_oe_o)
      else $error("no power-up alert after soft reset");
   // Flags clear only through bus accesses, which land while the clock line is low
   alert_fall_a: assert property ($fell(alert_oe_o) |-> !scl_i)
      else $error("alert released outside a bus access");
   stale_end_a: assert property ($fell(data_stale_o) |-> $past(conv_enable_o))
      else $error("stale cleared without conversion");
endmodule
bind sisc_core sisc_core_asserts chk_i (.*);

// [sisc_host_model.sv]
// Serial bus host model driving register reads and writes bit by bit
`timescale 1ns/1ps
module sisc_host_model (
   // Clock
   input  wire logic mclk_i,
   // Serial lines
   input  wire logic dev_oe_i,
   output      logic scl_o,
   output      logic sda_o
);
   logic pull_low = 1'b0;
   // Wired data line with pull-up: released reads high
   assign sda_o = ~(pull_low | dev_oe_i);
   initial scl_o = 1'b1;
   // Quarter bit; every change on the falling clock edge
   task automatic q();
      repeat (4) @(negedge mclk_i);
   endtask
   task automatic bitx(input logic b, output logic r);
      pull_low = ~b;
      q();
      scl_o = 1'b1;
      q();
      r = sda_o;
      q();
      scl_o = 1'b0;
      q();
   endtask
   // Start or repeated start: data falls while clock high
   task automatic start();
      pull_low = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      pull_low = 1'b1;
      q();
      scl_o = 1'b0;
      q();
   endtask
   task automatic stop();
      pull_low = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      pull_low = 1'b0;
      q();
   endtask
   // Ninth bit is always released: device acknowledge, or host end of read
   task automatic xfer(input logic [7:0] d, output logic [7:0] r);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r[i]);
      end
      bitx(1'b1, a);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] r;
      start();
      xfer({sisc_pkg::DEV_ADDR_DEF, 1'b0}, r);
      xfer(p, r);
      xfer(d, r);
      stop();
   endtask
   // Status read is how pending events get cleared
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      start();
      xfer({sisc_pkg::DEV_ADDR_DEF, 1'b0}, d);
      xfer(p, d);
      start();
      xfer({sisc_pkg::DEV_ADDR_DEF, 1'b1}, d);
      xfer(8'hFF, d);
      stop();
   endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the sensor alert core
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {logic [7:0] cfg; logic [4:0] hot; logic [7:0] exp;} sisc_row_t;
   // Config, out-of-window channels (clr grn ir tmp prx), expected status
   localparam sisc_row_t ROWS [9] = '{'{8'h01, 5'h10, 8'h01}, '{8'h05, 5'h08, 8'h01},
      '{8'h09, 5'h04, 8'h01}, '{8'h6D, 5'h02, 8'h01}, '{8'h8D, 5'h10, 8'h00},
      '{8'hA2, 5'h01, 8'h02}, '{8'hA0, 5'h01, 8'h00}, '{8'h00, 5'h10, 8'h00},
      '{8'hC3, 5'h1F, 8'h00}};
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        glitch = 1'b0;
   logic [1:0]  pst = 2'h0;
   logic [13:0] clr_d, grn_d, ir_d, tmp_d;
   logic [9:0]  prx_d;
   logic        scl, sda, sda_oe, alert_oe, conv_en, stale, restore;
   logic        amb_act, prx_act;
   logic [7:0]  d;
   int          n_fail = 0;
   int          total_checks = 0;
   // Clock, 100 ns period
   initial forever #50 mclk_i = ~mclk_i;
   sisc_host_model host (.mclk_i(mclk_i), .dev_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
   // Period long enough that a wake-up can be seen stale after the bus write ends
   sisc_core #(.CONV_CYCLES(64)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl),
      .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .alert_n_o(), .alert_oe_o(alert_oe),
      .clear_data_i(clr_d), .green_data_i(grn_d), .ir_data_i(ir_d), .temp_data_i(tmp_d),
      .prox_data_i(prx_d), .amb_upper_thr_i(14'h03E8), .amb_lower_thr_i(14'h0064),
      .prx_upper_thr_i(10'h1F4), .prx_lower_thr_i(10'h000), .ambient_persist_count_i(pst),
      .proximity_persist_count_i(pst), .supply_glitch_i(glitch), .conv_enable_o(conv_en),
      .amb_active_o(amb_act), .prx_active_o(prx_act), .data_stale_o(stale), .soft_reset_o(),
      .thr_restore_o(restore));
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Out-of-window values where the mask bit is set
   task automatic drive(input logic [4:0] h);
      clr_d = h[4] ? 14'h07D0 : 14'h01F4;
      grn_d = h[3] ? 14'h07D0 : 14'h01F4;
      ir_d = h[2] ? 14'h07D0 : 14'h01F4;
      tmp_d = h[1] ? 14'h07D0 : 14'h01F4;
      prx_d = h[0] ? 10'h320 : 10'h064;
   endtask
   task automatic wrap_up();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (100000) @(posedge mclk_i);
      n_fail++;
      wrap_up();
   end
   initial begin
      drive(5'h00);
      repeat (10) @(negedge mclk_i);
      rst_n_i = 1'b1;
      chk("reset alert", {7'h00, alert_oe}, 8'h01);
      host.rd(sisc_pkg::CONFIG_ADDR, d);
      chk("reset config", d, sisc_pkg::CONFIG_RST);
      host.wr(sisc_pkg::CONFIG_ADDR, 8'h00);
      host.rd(sisc_pkg::STATUS_ADDR, d);
      chk("reset status", d, sisc_pkg::STATUS_RST);
      host.rd(sisc_pkg::STATUS_ADDR, d);
      chk("status cleared", d, 8'h00);
      chk("alert released", {7'h00, alert_oe}, 8'h00);
      $display("reset test done");
      // Source select, enables and channel sets, one row each
      for (int i = 0; i < 9; i++) begin
         drive(5'h00);
         host.wr(sisc_pkg::CONFIG_ADDR, ROWS[i].cfg);
         repeat (100) @(negedge mclk_i);
         host.rd(sisc_pkg::STATUS_ADDR, d);
         drive(ROWS[i].hot);
         repeat (100) @(negedge mclk_i);
         chk("row alert", {7'h00, alert_oe}, {7'h00, |ROWS[i].exp});
         chk("row active", {6'h00, amb_act, prx_act}, {6'h00, ROWS[i].cfg[7:5] <= 3'h4,
            ROWS[i].cfg[7:5] inside {3'h3, 3'h4, 3'h5}});
         host.rd(sisc_pkg::STATUS_ADDR, d);
         chk("row status", d, ROWS[i].exp);
         host.rd(sisc_pkg::CONFIG_ADDR, d);
         chk("row config", d, ROWS[i].cfg);
         $display("row %0d done", i);
      end
      // Power save with an event pending; flag bits ignore writes
      host.wr(sisc_pkg::CONFIG_ADDR, 8'h01);
      drive(5'h10);
      repeat (100) @(negedge mclk_i);
      host.wr(sisc_pkg::STATUS_ADDR, 8'h0F);
      host.rd(sisc_pkg::STATUS_ADDR, d);
      chk("save status", d, 8'h08);
      chk("save conv", {7'h00, conv_en}, 8'h00);
      drive(5'h00);
      host.wr(sisc_pkg::STATUS_ADDR, 8'h00);
      chk("wake stale", {7'h00, stale}, 8'h01);
      repeat (100) @(negedge mclk_i);
      chk("fresh data", {7'h00, stale}, 8'h00);
      host.rd(8'h05, d);
      chk("unmapped read", d, 8'h00);
      $display("power save test done");
      // Supply glitch
      glitch = 1'b1;
      @(negedge mclk_i);
      glitch = 1'b0;
      chk("glitch alert", {6'h00, alert_oe, restore}, 8'h03);
      host.rd(sisc_pkg::STATUS_ADDR, d);
      chk("glitch status", d, 8'h04);
      // Soft reset restores config and raises the power-up flag
      host.wr(sisc_pkg::CONFIG_ADDR, 8'h0D);
      host.wr(sisc_pkg::STATUS_ADDR, 8'h10);
      repeat (40) @(negedge mclk_i);
      host.rd(sisc_pkg::STATUS_ADDR, d);
      chk("srst status", d, 8'h04);
      host.rd(sisc_pkg::CONFIG_ADDR, d);
      chk("srst config", d, 8'h20);
      $display("glitch and soft reset test done");
      wrap_up();
   end
endmodule
